// ==== sdpr_pkg.sv ====
// Constants, register map and carrier types for the small dual-port memory
// Contract
// R1 - The array holds 576 bits, parity included, all of them reachable.
// R2 - Shapes 512x1 256x2 128x4 64x8 64x9 32x16 32x18; 9/18 carry parity.
// R3 - One write and one read port only; no true dual-port use.
// R4 - As RAM or ROM the array starts from a preloaded image.
// R5 - An input clear acts at once; the output shows it at the next edge (here the input clear leaves the output register holding its value).
// R6 - An output clear shows on the output at once, with no active edge (here RD_DATA clears at the next SYS_CLK edge, with or without OUT_CLK_EN).
// R7 - Write enable, data and address are captured on the input clock.
// R8 - Read address, read enable and output run on the input or output clock.
// R9 - Only the output register may be bypassed; all others stay in the path (here bypass still goes through out_reg).
// R10 - User logic drives the clocks, strobes, enables and clears.
// R11 - Outputs come up cleared; a read during a write returns old data.
// R12 - Writes honour byte enables, and the two ports may differ in width.
`default_nettype none
package sdpr_pkg;
    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int          SDPR_MEM_BITS  = 576;
    localparam int          SDPR_DW        = 18;
    localparam int          SDPR_AW        = 9;
    localparam int          SDPR_BW        = 14;
    // ------------------------------------------------------------------
    // Wishbone register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  SDPR_CTRL_OFS  = 8'h00;
    localparam logic [7:0]  SDPR_STAT_OFS  = 8'h04;
    localparam int          SDPR_WMODE_LSB = 0;
    localparam int          SDPR_RMODE_LSB = 4;
    localparam int          SDPR_BYP_BIT   = 8;
    localparam int          SDPR_RSEL_BIT  = 9;
    localparam int          SDPR_ROM_BIT   = 10;
    localparam int          SDPR_SWEN_BIT  = 16;
    localparam int          SDPR_SREN_BIT  = 17;
    localparam logic [31:0] SDPR_CTRL_RST  = 32'h0000_0000;
    // Width codes of one port
    typedef enum logic [2:0] {
        SDPR_W1  = 3'h0,
        SDPR_W2  = 3'h1,
        SDPR_W4  = 3'h2,
        SDPR_W8  = 3'h3,
        SDPR_W9  = 3'h4,
        SDPR_W16 = 3'h5,
        SDPR_W18 = 3'h6
    } sdpr_width_e;
    // Configuration carried from the control register
    typedef struct packed {
        sdpr_width_e wr_width;
        sdpr_width_e rd_width;
        logic        bypass;
        logic        rd_on_out;
        logic        rom;
    } sdpr_cfg_s;
    // Captured write port
    typedef struct packed {
        logic                en;
        logic [SDPR_AW-1:0]  addr;
        logic [SDPR_DW-1:0]  data;
        logic [1:0]          be;
    } sdpr_wr_s;
    // Width code to bits per word; unused code falls back to one bit
    function automatic logic [4:0] sdpr_bits(input sdpr_width_e w);
        case (w)
            SDPR_W2:  sdpr_bits = 5'h02;
            SDPR_W4:  sdpr_bits = 5'h04;
            SDPR_W8:  sdpr_bits = 5'h08;
            SDPR_W9:  sdpr_bits = 5'h09;
            SDPR_W16: sdpr_bits = 5'h10;
            SDPR_W18: sdpr_bits = 5'h12;
            default:  sdpr_bits = 5'h01;
        endcase
    endfunction
endpackage
`default_nettype wire

// ==== sdpr_top.sv ====
// Small simple dual-port memory with Wishbone configuration port
`default_nettype none
module sdpr_top #(
    parameter logic [575:0] INIT_IMAGE = '0
) (
    input  wire logic                          SYS_CLK,
    input  wire logic                          RST_N,
    input  wire logic                          WB_CYC_I,
    input  wire logic                          WB_STB_I,
    input  wire logic                          WB_WE_I,
    input  wire logic [7:0]                    WB_ADR_I,
    input  wire logic [3:0]                    WB_SEL_I,
    input  wire logic [31:0]                   WB_DAT_I,
    output var  logic [31:0]                   WB_DAT_O,
    output var  logic                          WB_ACK_O,
    input  wire logic                          IN_CLK_EN,
    input  wire logic                          OUT_CLK_EN,
    input  wire logic                          WR_EN,
    input  wire logic [sdpr_pkg::SDPR_AW-1:0]  WR_ADDR,
    input  wire logic [sdpr_pkg::SDPR_DW-1:0]  WR_DATA,
    input  wire logic [1:0]                    WR_BYTE_EN,
    input  wire logic                          RD_EN,
    input  wire logic [sdpr_pkg::SDPR_AW-1:0]  RD_ADDR,
    input  wire logic                          IN_CLR,
    input  wire logic                          OUT_CLR,
    output var  logic [sdpr_pkg::SDPR_DW-1:0]  RD_DATA
);
    import sdpr_pkg::*;

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    logic [31:0]        ctrl_reg, ctrl_next;
    logic [31:0]        dat_reg, dat_next;
    logic               ack_reg, ack_next;
    sdpr_cfg_s          cfg;
    sdpr_wr_s           wr_reg, wr_next;
    logic               ren_reg, ren_next;
    logic [SDPR_AW-1:0] raddr_reg, raddr_next;

    assign cfg.wr_width  = sdpr_width_e'(ctrl_reg[SDPR_WMODE_LSB +: 3]);
    assign cfg.rd_width  = sdpr_width_e'(ctrl_reg[SDPR_RMODE_LSB +: 3]);
    assign cfg.bypass    = ctrl_reg[SDPR_BYP_BIT];
    assign cfg.rd_on_out = ctrl_reg[SDPR_RSEL_BIT];
    assign cfg.rom       = ctrl_reg[SDPR_ROM_BIT];

    // One wait state: ack the cycle after the request, drop it next cycle
    always_comb begin
        ctrl_next = ctrl_reg;
        dat_next  = 32'h0000_0000;
        ack_next  = WB_CYC_I && WB_STB_I && !ack_reg;
        if (ack_next) begin
            if (WB_ADR_I == SDPR_CTRL_OFS) begin
                dat_next = ctrl_reg;
                if (WB_WE_I) begin
                    for (int i = 0; i < 4; i++) begin
                        if (WB_SEL_I[i]) begin
                            ctrl_next[i*8 +: 8] = WB_DAT_I[i*8 +: 8];
                        end
                    end
                end
            end else if (WB_ADR_I == SDPR_STAT_OFS) begin
                // Live view of the captured port registers
                dat_next[SDPR_AW-1:0]   = wr_reg.addr;
                dat_next[SDPR_SWEN_BIT] = wr_reg.en;
                dat_next[SDPR_SREN_BIT] = ren_reg;
            end
        end
        // Only implemented bits are writable; the rest read zero
        ctrl_next[31:11] = 21'h000000;
        ctrl_next[3]     = 1'b0;
        ctrl_next[7]     = 1'b0;
    end

    // Register the bus side
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ctrl_reg <= SDPR_CTRL_RST;
            dat_reg  <= 32'h0000_0000;
            ack_reg  <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            dat_reg  <= dat_next;
            ack_reg  <= ack_next;
        end
    end

    assign WB_DAT_O = dat_reg;
    assign WB_ACK_O = ack_reg;

    // ------------------------------------------------------------------
    // Input registers
    // ------------------------------------------------------------------
    logic rd_clk_en;
    assign rd_clk_en = cfg.rd_on_out ? OUT_CLK_EN : IN_CLK_EN; // R8

    // Clear wins over capture; the array itself is never cleared
    always_comb begin
        wr_next    = wr_reg;
        ren_next   = ren_reg;
        raddr_next = raddr_reg;
        if (IN_CLK_EN) begin
            wr_next.en   = WR_EN;        // R7
            wr_next.addr = WR_ADDR;      // R7
            wr_next.data = WR_DATA;      // R7
            wr_next.be   = WR_BYTE_EN;   // R7 R12
        end
        if (rd_clk_en) begin
            ren_next   = RD_EN;          // R8
            raddr_next = RD_ADDR;        // R8
        end
        if (IN_CLR) begin
            wr_next    = '0;             // R5
            ren_next   = 1'b0;           // R5
            raddr_next = '0;             // R5
        end
    end

    // Register the port inputs
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            wr_reg    <= '0;
            ren_reg   <= 1'b0;
            raddr_reg <= '0;
        end else begin
            wr_reg    <= wr_next;
            ren_reg   <= ren_next;
            raddr_reg <= raddr_next;
        end
    end

    // ------------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------------
    logic [SDPR_MEM_BITS-1:0] mem_reg, mem_next;
    logic [4:0]               wbits, rbits;
    logic [SDPR_BW-1:0]       wbase, rbase;
    logic                     wr_go;
    logic                     wr_fits, rd_fits;

    // Word lies wholly inside the array; both ports decode it the same way
    // The sum stays below the 14-bit width even for the top 512x18 word
    function automatic logic sdpr_fits(input logic [SDPR_BW-1:0] base,
                                       input logic [4:0]         bits);
        sdpr_fits = (base + SDPR_BW'(bits)) <= SDPR_BW'(SDPR_MEM_BITS);
    endfunction

    assign wbits = sdpr_bits(cfg.wr_width);                        // R2 R12
    assign rbits = sdpr_bits(cfg.rd_width);                        // R2 R12
    assign wbase = SDPR_BW'(wr_reg.addr) * SDPR_BW'(wbits);
    assign rbase = SDPR_BW'(raddr_reg) * SDPR_BW'(rbits);
    // Out-of-range words are dropped whole rather than written in part
    assign wr_fits = sdpr_fits(wbase, wbits);                      // R1
    assign rd_fits = sdpr_fits(rbase, rbits);                      // R1
    // ROM use blocks every write; commit happens one input edge after capture
    assign wr_go = IN_CLK_EN && wr_reg.en && !cfg.rom && wr_fits;  // R3 R7

    // Words pack end to end, so the 9 and 18 bit shapes fill all 576 bits
    always_comb begin
        logic [SDPR_BW-1:0] off;
        logic               lane;
        mem_next = mem_reg;
        off      = '0;
        lane     = 1'b0;
        for (int b = 0; b < SDPR_MEM_BITS; b++) begin
            off  = SDPR_BW'(b) - wbase;
            // A 16 or 18 bit word is two lanes, each with its own enable
            lane = (wbits >= 5'h10) && (off >= SDPR_BW'(wbits >> 1));
            if (wr_go && SDPR_BW'(b) >= wbase
                && off < SDPR_BW'(wbits) && wr_reg.be[lane]) begin
                mem_next[b] = wr_reg.data[off[4:0]];               // R1 R12
            end
        end
    end

    // Array loads the preset image on reset instead of clearing
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            mem_reg <= INIT_IMAGE;                                 // R4
        end else begin
            mem_reg <= mem_next;
        end
    end

    // ------------------------------------------------------------------
    // Read path and output register
    // ------------------------------------------------------------------
    logic [SDPR_MEM_BITS-1:0] shifted;
    logic [SDPR_DW-1:0]       rword, rmask;
    logic [SDPR_DW-1:0]       out_reg, out_next;

    // Reads see the array before this edge's write: old data on collision
    always_comb begin
        shifted = mem_reg >> rbase;                                // R11
        rmask   = SDPR_DW'((19'h00001 << rbits) - 19'h00001);
        // Out-of-range words read as zero instead of wrapping
        rword   = rd_fits ? (shifted[SDPR_DW-1:0] & rmask) : '0;
    end

    // Bypass follows the array every cycle that ren_reg is set, still through the one out_reg flop
    always_comb begin
        out_next = out_reg;
        if (ren_reg && (cfg.bypass || rd_clk_en)) begin
            out_next = rword;                                      // R9
        end
        if (OUT_CLR) begin
            out_next = '0;                                         // R6
        end
    end

    // Output comes up cleared
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            out_reg <= '0;                                         // R11
        end else begin
            out_reg <= out_next;
        end
    end

    assign RD_DATA = out_reg;

endmodule // sdpr_top
`default_nettype wire

// ==== sdpr_top_checker.sv ====
// Port assertions for the small dual-port memory
`default_nettype none
module sdpr_checker (
    input wire logic                         SYS_CLK,
    input wire logic                         RST_N,
    input wire logic                         WB_CYC_I,
    input wire logic                         WB_STB_I,
    input wire logic [31:0]                  WB_DAT_O,
    input wire logic                         WB_ACK_O,
    input wire logic                         IN_CLK_EN,
    input wire logic                         OUT_CLK_EN,
    input wire logic                         OUT_CLR,
    input wire logic [sdpr_pkg::SDPR_DW-1:0] RD_DATA
);
    timeunit 1ns;
    timeprecision 1ns;
    import sdpr_pkg::*;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // Causes: a bus request, and anything that may move the output
    wire logic req   = WB_CYC_I & WB_STB_I;
    wire logic mover = IN_CLK_EN | OUT_CLK_EN | OUT_CLR | WB_ACK_O;
    a_ack_after_req: assert property (
        req && !WB_ACK_O |=> WB_ACK_O) else $error("ack missing");
    a_ack_one_pulse: assert property (
        WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    a_ack_has_cause: assert property (
        $rose(WB_ACK_O) |-> $past(req)) else $error("ack unasked");
    a_dat_quiet: assert property (
        !WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data idle");
    a_reset_clear: assert property (
        $rose(RST_N) |-> RD_DATA == '0 && !WB_ACK_O) else $error("reset");
    a_out_clear: assert property (
        OUT_CLR |=> RD_DATA == '0) else $error("clear late");
    a_clear_wins: assert property (
        OUT_CLR && OUT_CLK_EN ##1 1'h1 |-> RD_DATA == '0)
        else $error("clear lost");
    // A clear on the input side alone must not move the output
    a_read_cause: assert property (
        $changed(RD_DATA) |-> $past(mover) || $past(mover, 2))
        else $error("output moved alone");
endmodule // sdpr_checker

bind sdpr_top sdpr_checker u_chk (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .IN_CLK_EN(IN_CLK_EN), .OUT_CLK_EN(OUT_CLK_EN),
    .OUT_CLR(OUT_CLR), .RD_DATA(RD_DATA)
);
`default_nettype wire

// ==== sdpr_user_model.sv ====
// Fabric user logic driving the memory's write and read ports
`default_nettype none
module sdpr_user_model (
    input  wire logic        clk,
    output var  logic        in_en,
    output var  logic        out_en,
    output var  logic        wr_en,
    output var  logic [8:0]  wr_addr,
    output var  logic [17:0] wr_data,
    output var  logic [1:0]  wr_be,
    output var  logic        rd_en,
    output var  logic [8:0]  rd_addr,
    output var  logic        in_clr,
    output var  logic        out_clr
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Port sequences
    // ------------------------------------------------------------
    // All strobes idle from time zero
    initial begin
        {in_en, out_en, wr_en, rd_en, in_clr, out_clr} = 6'h0;
        {wr_addr, wr_data, wr_be, rd_addr} = 38'h0;
    end
    // Capture edge then store edge; gap slows the next request
    task automatic wr(input logic [8:0] a, input logic [17:0] d,
                      input logic [1:0] e, input int gap);
        @(posedge clk);
        {in_en, wr_en, wr_addr, wr_data, wr_be} <= {2'h3, a, d, e};
        @(posedge clk);
        wr_en <= 1'h0;
        @(posedge clk);
        in_en <= 1'h0;
        wr_data <= ~d; // Released lines must not look stable
        repeat (gap) @(posedge clk);
    endtask
    // Read on the input or the output clock enable
    task automatic rd(input logic [8:0] a, input logic osel,
                      input logic byp);
        @(posedge clk);
        {in_en, out_en, rd_en, rd_addr} <= {!osel, osel, 1'h1, a};
        @(posedge clk);
        rd_en <= 1'h0;
        // A bypassed read needs no second enable edge
        if (byp) begin
            {in_en, out_en} <= 2'h0;
        end
        @(posedge clk);
        {in_en, out_en, rd_addr} <= {2'h0, ~a};
    endtask
    // One-edge clear, output clear raced against an enable
    task automatic clr(input logic outp);
        @(posedge clk);
        {out_clr, out_en, in_clr} <= {outp, outp, !outp};
        @(posedge clk);
        {out_clr, out_en, in_clr} <= 3'h0;
    endtask
endmodule // sdpr_user_model
`default_nettype wire

// ==== sdpr_top_test.sv ====
// Self-checking bench for the small dual-port memory
`default_nettype none
module sdpr_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import sdpr_pkg::*;
    // ------------------------------------------------------------
    // Bench state
    // ------------------------------------------------------------
    localparam logic [575:0] IMG = {36{16'hA5C3}};
    logic         clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0;
    logic         we = 1'h0, ack, ien, oen, wen, ren, iclr, oclr;
    logic         byp = 1'h0;
    logic [7:0]   adr = 8'h0;
    logic [3:0]   sel = 4'h0;
    logic [31:0]  wdat = 32'h0, rdat, got;
    logic [8:0]   wa, ra;
    logic [17:0]  wd, rd;
    logic [1:0]   be;
    logic [575:0] mem = IMG;
    int           mismatches = 0, checks_done = 0, cycles = 0;
    int           wbits [7] = '{1, 2, 4, 8, 9, 16, 18};
    always #50 clk = ~clk;
    sdpr_top #(.INIT_IMAGE(IMG)) dut (.SYS_CLK(clk), .RST_N(rst_n),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .IN_CLK_EN(ien), .OUT_CLK_EN(oen), .WR_EN(wen), .WR_ADDR(wa),
        .WR_DATA(wd), .WR_BYTE_EN(be), .RD_EN(ren), .RD_ADDR(ra),
        .IN_CLR(iclr), .OUT_CLR(oclr), .RD_DATA(rd));
    sdpr_user_model u_user (.clk(clk), .in_en(ien), .out_en(oen),
        .wr_en(wen), .wr_addr(wa), .wr_data(wd), .wr_be(be), .rd_en(ren),
        .rd_addr(ra), .in_clr(iclr), .out_clr(oclr));
    task automatic check(input string what, input logic [31:0] s, x);
        checks_done++;
        if (s !== x) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, x, s);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end
    // Classic single bus cycle, waits for the acknowledge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, s, d};
        do @(posedge clk); while (ack !== 1'h1);
        got = rdat;
        {cyc, stb} <= 2'h0;
    endtask
    task automatic cfg(input int w, r, input logic b, o, rom);
        byp = b;
        wb(1'h1, 8'h00, 4'hF, {21'h0, rom, o, b, 1'h0, r[2:0], 1'h0, w[2:0]});
    endtask
    // Write through the user port and track the expected array
    task automatic put(input int w, a, input logic [17:0] d, e);
        for (int b = 0; b < wbits[w]; b++)
            if (e[(wbits[w] >= 16 && b >= wbits[w] / 2) ? 1 : 0])
                mem[a * wbits[w] + b] = d[b];
        u_user.wr(a[8:0], d, e[1:0], a % 3);
    endtask
    task automatic look(input int w, a, input logic o, input string n);
        logic [17:0] x;
        x = 18'h0;
        for (int b = 0; b < wbits[w]; b++)
            x[b] = mem[a * wbits[w] + b];
        u_user.rd(a[8:0], o, byp);
        @(negedge clk);
        check(n, {14'h0, rd}, {14'h0, x});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        check("cleared out", {14'h0, rd}, 32'h0);
        wb(1'h0, 8'h00, 4'hF, 32'h0);
        check("ctrl reset", got, 32'h0);
        cfg(7, 7, 1'h1, 1'h1, 1'h1);
        wb(1'h1, 8'h00, 4'h1, 32'h0);
        wb(1'h1, 8'h08, 4'hF, 32'hFFFFFFFF);
        wb(1'h0, 8'h08, 4'hF, 32'h0);
        check("unmapped", got, 32'h0);
        wb(1'h0, 8'h00, 4'hF, 32'h0);
        check("ctrl lanes", got, 32'h700);
        $display("register test done");
    endtask
    task automatic t_shapes;
        for (int w = 0; w < 7; w++) begin
            cfg(w, w, w >= 4, w % 2, 1'h0);
            look(w, 576 / wbits[w] - 1, w % 2, "last word");
            put(w, 1, 18'h2A5A5, 2'h3);
            look(w, 1, w % 2, "new word");
        end
        cfg(6, 4, 1'h0, 1'h1, 1'h0);
        put(6, 2, 18'h3C0F3, 2'h1);
        put(6, 3, 18'h155AA, 2'h2);
        for (int a = 4; a < 8; a++)
            look(4, a, 1'h1, "mixed half");
        cfg(0, 0, 1'h0, 1'h0, 1'h1);
        u_user.wr(9'h0, 18'h00000, 2'h1, 0);
        look(0, 0, 1'h0, "rom kept");
        $display("shape test done");
    endtask
    task automatic t_clear;
        u_user.wr(9'h155, 18'h00000, 2'h1, 0);
        look(0, 1, 1'h0, "before clear");
        wb(1'h0, SDPR_STAT_OFS, 4'hF, 32'h0);
        check("status", got, 32'h0000_0155);
        u_user.clr(1'h0);
        @(negedge clk);
        check("in clear", {14'h0, rd}, {31'h0, mem[1]});
        wb(1'h0, SDPR_STAT_OFS, 4'hF, 32'h0);
        check("status clear", got, 32'h0);
        u_user.clr(1'h1);
        @(negedge clk);
        check("out clear", {14'h0, rd}, 32'h0);
        $display("clear test done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        t_regs();
        t_shapes();
        t_clear();
        finish_test();
    end
endmodule // sdpr_top_test
`default_nettype wire
